// ---- qdc_map.vh ----
// Constants for the quadrature decoder core
`ifndef QDC_MAP_VH
`define QDC_MAP_VH
// Count modes
`define QDC_CM_X4      3'h0
`define QDC_CM_X2      3'h1
`define QDC_CM_X1      3'h2
`define QDC_CM_UPDN    3'h3
`define QDC_CM_SGN2    3'h4
`define QDC_CM_SGN1    3'h5
// Initialise trigger modes for home and index inputs
`define QDC_TM_OFF     2'h0
`define QDC_TM_RISE    2'h1
`define QDC_TM_FALL    2'h2
`define QDC_TM_BOTH    2'h3
// Filter sample count field offset: code 0 means 3 samples
`define QDC_FILT_BASE  4'h3
`define QDC_FILT_MAX   4'ha
// Prescaler select field width (2^0 .. 2^15)
`define QDC_PRE_W      4
// Reset values
`define QDC_ZERO32     32'h0000_0000
`define QDC_ZERO16     16'h0000
`endif

// ---- qdc_filter.v ----
// Input sample filter for one sensor input
`timescale 1ns/100ps
`default_nettype none
module qdc_filter (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Settings
  input  wire       bypass,
  input  wire [7:0] sample_period,
  input  wire [2:0] sample_count,
  // Signal
  input  wire       raw_in,
  output reg        filt_out
);
  `include "qdc_map.vh"

  reg  [1:0] sync;
  reg  [7:0] per_cnt;
  reg  [3:0] agree;
  wire       tick;
  wire [3:0] need;

  assign tick = (per_cnt == 8'h00);
  assign need = {1'b0, sample_count} + `QDC_FILT_BASE;

  // Two-stage synchroniser
  always @(posedge clk) begin
    if (rst) begin
      sync <= 2'h0;
    end else begin
      sync <= {sync[0], raw_in};
    end
  end

  // Sample interval divider and agreement counter
  always @(posedge clk) begin
    if (rst) begin
      per_cnt  <= 8'h00;
      agree    <= 4'h0;
      filt_out <= 1'b0;
    end else if (bypass || sample_period == 8'h00) begin
      filt_out <= sync[1];
      agree    <= 4'h0;
      per_cnt  <= 8'h00;
    end else begin
      per_cnt <= tick ? sample_period - 8'h01 : per_cnt - 8'h01;
      if (tick) begin
        if (sync[1] == filt_out) begin
          agree <= 4'h0;
        end else if (agree + 4'h1 >= need) begin
          filt_out <= sync[1];
          agree    <= 4'h0;
        end else begin
          agree <= agree + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- qdc_core.v ----
// Quadrature decoder core: counters, compare, watchdog, timers
`timescale 1ns/100ps
`default_nettype none
//Contract
// - Reverse setting inverts the decoded counting direction of position.
// - Select modulo wrapping or one-shot counting without wrap.
// - With DMA enabled, request refill of buffered compare, start and wrap values.
// - Load mode chooses when buffered values move to active registers.
// - Trigger rising edge may load position from start value.
// - Trigger rising edge may clear position, turn and delta counters.
// - Trigger rising edge may copy counters to hold registers.
// - Each sensor input has a bypass control passing it unfiltered; trigger_in has none, being only synchronised.
// - Motion watchdog enabled by a bit with programmable timeout.
// - Filter accepts transition after programmed count of agreeing samples.
// - Filter sampling interval programmable 0 to 255 clock cycles.
// - Home/enable input initialises position by selectable trigger mode.
// - Index/preset input initialises position by its own trigger mode.
// - Four 32-bit compare values are compared with position.
// - Modulo mode wraps at 32-bit wrap value, otherwise ignored.
// - A 32-bit start value loads position on initialisation.
// - With period measurement, delta snapshot updates only on delta read.
// - Edge and period timers share a power-of-two prescaler up to 32768.
// - Agreeing sample count is programmable from 3 to 10.
// - Hit pulse on compare match or on counter read, as selected.
// - Turn counter steps on index or on modulo roll-over/under.
module qdc_core (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Sensor pins
  input  wire        quad_in_a,
  input  wire        quad_in_b,
  input  wire        index_in,
  input  wire        home_in,
  input  wire        trigger_in,
  // Mode settings
  input  wire [2:0]  count_mode,
  input  wire        reverse_en,
  input  wire        one_shot,
  input  wire        modulo_en,
  input  wire        turn_on_roll,
  input  wire        hit_on_read,
  input  wire        period_meas_en,
  input  wire [1:0]  home_mode,
  input  wire [1:0]  index_mode,
  // Trigger actions
  input  wire        trig_init_en,
  input  wire        trig_clear_en,
  input  wire        trig_hold_en,
  // Filter settings
  input  wire [3:0]  filt_bypass,
  input  wire [7:0]  filt_period,
  input  wire [2:0]  filt_count,
  // Watchdog and prescaler
  input  wire        wdog_en,
  input  wire [15:0] wdog_timeout,
  input  wire [3:0]  prescale_sel,
  // Buffered values
  input  wire        buf_load_mode,
  input  wire        buf_write,
  input  wire [31:0] buf_start_value,
  input  wire [31:0] buf_wrap_value,
  input  wire [31:0] buf_match_value0,
  input  wire [31:0] buf_match_value1,
  input  wire [31:0] buf_match_value2,
  input  wire [31:0] buf_match_value3,
  input  wire        dma_en,
  input  wire        dma_ack,
  output reg         dma_req,
  // Software access
  input  wire        sw_load,
  input  wire [31:0] sw_load_value,
  input  wire        delta_read,
  input  wire        counters_read,
  // Counters and status
  output reg  [31:0] position,
  output reg  [15:0] shaft_delta,
  output reg  [15:0] turn_count,
  output reg  [31:0] position_snapshot,
  output reg  [15:0] shaft_delta_snapshot,
  output reg  [15:0] turn_snapshot,
  output reg  [15:0] edge_age_timer,
  output reg  [15:0] delta_period_timer,
  output reg  [15:0] delta_period_snapshot,
  output reg         last_dir_up,
  output reg         wdog_timeout_flag,
  input  wire        wdog_flag_clear,
  output reg         compare_hit_pulse
);
  `include "qdc_map.vh"

  // Filtered inputs
  wire fa;
  wire fb;
  wire fi;
  wire fh;
  reg  [1:0] trig_sync;
  reg  pa;
  reg  pb;
  reg  pi;
  reg  ph;
  reg  pt;
  // Active copies of buffered values
  reg  [31:0] start_value;
  reg  [31:0] wrap_value;
  reg  [31:0] match_value [0:3];
  reg  [15:0] wdog_cnt;
  reg  [15:0] pre_cnt;
  reg         hit_d;

  // Filter instances; trigger only synchronised
  qdc_filter u_fa (.clk(clk), .rst(rst), .bypass(filt_bypass[0]), .sample_period(filt_period),
                   .sample_count(filt_count), .raw_in(quad_in_a), .filt_out(fa));
  qdc_filter u_fb (.clk(clk), .rst(rst), .bypass(filt_bypass[1]), .sample_period(filt_period),
                   .sample_count(filt_count), .raw_in(quad_in_b), .filt_out(fb));
  qdc_filter u_fi (.clk(clk), .rst(rst), .bypass(filt_bypass[2]), .sample_period(filt_period),
                   .sample_count(filt_count), .raw_in(index_in), .filt_out(fi));
  qdc_filter u_fh (.clk(clk), .rst(rst), .bypass(filt_bypass[3]), .sample_period(filt_period),
                   .sample_count(filt_count), .raw_in(home_in), .filt_out(fh));

  // Mode edge test for index and home initialise triggers
  function edge_hit;
    input [1:0] mode;
    input       now;
    input       was;
    begin
      case (mode)
        `QDC_TM_RISE: edge_hit = now & ~was;
        `QDC_TM_FALL: edge_hit = ~now & was;
        `QDC_TM_BOTH: edge_hit = now ^ was;
        default:      edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Decode phase edges into a count and a direction
  reg cnt_ev;
  reg dir_raw;
  always @* begin
    cnt_ev  = 1'b0;
    dir_raw = 1'b1;
    case (count_mode)
      `QDC_CM_X4: begin
        cnt_ev  = (fa ^ pa) | (fb ^ pb);
        dir_raw = (fa ^ pa) ? (fa ^ fb) : ~(fa ^ fb);
      end
      `QDC_CM_X2: begin
        cnt_ev  = fa ^ pa;
        dir_raw = fa ^ fb;
      end
      `QDC_CM_X1: begin
        cnt_ev  = fa & ~pa;
        dir_raw = ~fb;
      end
      `QDC_CM_UPDN: begin
        cnt_ev  = (fa & ~pa) ^ (fb & ~pb);
        dir_raw = fa & ~pa;
      end
      `QDC_CM_SGN2: begin
        cnt_ev  = fa ^ pa;
        dir_raw = ~fb;
      end
      `QDC_CM_SGN1: begin
        cnt_ev  = fa & ~pa;
        dir_raw = ~fb;
      end
      default: begin
        cnt_ev  = 1'b0;
        dir_raw = 1'b1;
      end
    endcase
  end

  wire dir_up     = dir_raw ^ reverse_en;
  wire trig_rise  = trig_sync[1] & ~pt;
  wire pos_init   = edge_hit(home_mode, fh, ph) | edge_hit(index_mode, fi, pi) |
                    (trig_rise & trig_init_en);
  wire trig_clr   = trig_rise & trig_clear_en;
  wire trig_hold  = trig_rise & trig_hold_en;
  wire at_top     = (position == wrap_value);
  wire at_bottom  = (position == start_value);
  wire limit_hit  = dir_up ? at_top : at_bottom;
  wire roll_over  = cnt_ev & modulo_en & limit_hit & ~one_shot;
  wire step_ok    = cnt_ev & ~(modulo_en & limit_hit & one_shot);
  wire index_rise = fi & ~pi;
  wire [15:0] pre_mask = (16'h0001 << prescale_sel) - 16'h0001;
  wire pre_tick   = ((pre_cnt & pre_mask) == pre_mask);
  wire buf_move   = buf_load_mode ? (pos_init | roll_over) : buf_write;
  wire match_now  = (position == match_value[0]) | (position == match_value[1]) |
                    (position == match_value[2]) | (position == match_value[3]);

  // Previous levels for edge detection
  always @(posedge clk) begin
    if (rst) begin
      trig_sync <= 2'h0;
      pa <= 1'b0;
      pb <= 1'b0;
      pi <= 1'b0;
      ph <= 1'b0;
      pt <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[0], trigger_in};
      pa <= fa;
      pb <= fb;
      pi <= fi;
      ph <= fh;
      pt <= trig_sync[1];
    end
  end

  // Buffered values and DMA refill request
  always @(posedge clk) begin
    if (rst) begin
      start_value    <= `QDC_ZERO32;
      wrap_value     <= `QDC_ZERO32;
      match_value[0] <= `QDC_ZERO32;
      match_value[1] <= `QDC_ZERO32;
      match_value[2] <= `QDC_ZERO32;
      match_value[3] <= `QDC_ZERO32;
      dma_req        <= 1'b0;
    end else begin
      if (buf_move) begin
        start_value    <= buf_start_value;
        wrap_value     <= buf_wrap_value;
        match_value[0] <= buf_match_value0;
        match_value[1] <= buf_match_value1;
        match_value[2] <= buf_match_value2;
        match_value[3] <= buf_match_value3;
      end
      if (buf_move && dma_en) begin
        dma_req <= 1'b1;
      end else if (dma_ack || !dma_en) begin
        dma_req <= 1'b0;
      end
    end
  end

  // Position, delta and turn counters; software preload assumed in range
  always @(posedge clk) begin
    if (rst) begin
      position    <= `QDC_ZERO32;
      shaft_delta <= `QDC_ZERO16;
      turn_count  <= `QDC_ZERO16;
      last_dir_up <= 1'b1;
    end else if (trig_clr) begin
      position    <= `QDC_ZERO32;
      shaft_delta <= `QDC_ZERO16;
      turn_count  <= `QDC_ZERO16;
    end else if (sw_load) begin
      position <= sw_load_value;
    end else begin
      if (pos_init) begin
        position <= start_value;
      end else if (roll_over) begin
        position <= dir_up ? start_value : wrap_value;
      end else if (step_ok) begin
        position <= dir_up ? position + 32'h1 : position - 32'h1;
      end
      if (cnt_ev) begin
        last_dir_up <= dir_up;
      end
      if (delta_read) begin
        shaft_delta <= `QDC_ZERO16;
      end else if (cnt_ev) begin
        shaft_delta <= (dir_raw ? shaft_delta + 16'h1 : shaft_delta - 16'h1);
      end
      if (turn_on_roll ? roll_over : index_rise) begin
        turn_count <= dir_up ? turn_count + 16'h1 : turn_count - 16'h1;
      end
    end
  end

  // Hold registers
  always @(posedge clk) begin
    if (rst) begin
      position_snapshot     <= `QDC_ZERO32;
      shaft_delta_snapshot  <= `QDC_ZERO16;
      turn_snapshot         <= `QDC_ZERO16;
      delta_period_snapshot <= `QDC_ZERO16;
    end else begin
      if (trig_hold || counters_read) begin
        position_snapshot <= position;
        turn_snapshot     <= turn_count;
      end
      if (period_meas_en ? delta_read : (trig_hold || counters_read || delta_read)) begin
        shaft_delta_snapshot  <= shaft_delta;
        delta_period_snapshot <= delta_period_timer;
      end
    end
  end

  // Prescaled edge age and delta period timers
  always @(posedge clk) begin
    if (rst) begin
      pre_cnt            <= `QDC_ZERO16;
      edge_age_timer     <= `QDC_ZERO16;
      delta_period_timer <= `QDC_ZERO16;
    end else begin
      pre_cnt <= pre_tick ? `QDC_ZERO16 : pre_cnt + 16'h1;
      if (cnt_ev) begin
        edge_age_timer <= `QDC_ZERO16;
      end else if (pre_tick && edge_age_timer != 16'hffff) begin
        edge_age_timer <= edge_age_timer + 16'h1;
      end
      if (delta_read) begin
        delta_period_timer <= `QDC_ZERO16;
      end else if (pre_tick && delta_period_timer != 16'hffff) begin
        delta_period_timer <= delta_period_timer + 16'h1;
      end
    end
  end

  // Motion watchdog; a new timeout wins over a clear in the same cycle
  always @(posedge clk) begin
    if (rst) begin
      wdog_cnt          <= `QDC_ZERO16;
      wdog_timeout_flag <= 1'b0;
    end else if (!wdog_en || cnt_ev) begin
      wdog_cnt          <= `QDC_ZERO16;
      wdog_timeout_flag <= wdog_timeout_flag & ~wdog_flag_clear;
    end else if (wdog_cnt == wdog_timeout) begin
      wdog_cnt          <= `QDC_ZERO16;
      wdog_timeout_flag <= 1'b1;
    end else begin
      wdog_cnt          <= wdog_cnt + 16'h1;
      wdog_timeout_flag <= wdog_timeout_flag & ~wdog_flag_clear;
    end
  end

  // Compare hit pulse: match entry or counter read
  always @(posedge clk) begin
    if (rst) begin
      hit_d             <= 1'b0;
      compare_hit_pulse <= 1'b0;
    end else begin
      hit_d <= match_now;
      if (hit_on_read) begin
        compare_hit_pulse <= counters_read | delta_read;
      end else begin
        compare_hit_pulse <= match_now & ~hit_d;
      end
    end
  end
endmodule
`default_nettype wire

// ---- qdc_core_sva.sv ----
// Port assertions for the quadrature decoder core
`timescale 1ns/100ps
`default_nettype none
module qdc_core_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Inputs watched
  input wire logic        trigger_in,
  input wire logic        trig_clear_en,
  input wire logic        trig_hold_en,
  input wire logic        sw_load,
  input wire logic [31:0] sw_load_value,
  input wire logic        hit_on_read,
  input wire logic        counters_read,
  input wire logic        delta_read,
  input wire logic        period_meas_en,
  input wire logic        wdog_en,
  input wire logic [15:0] wdog_timeout,
  input wire logic        wdog_flag_clear,
  input wire logic        buf_write,
  input wire logic        dma_ack,
  // Outputs watched
  input wire logic        dma_req,
  input wire logic [31:0] position,
  input wire logic [15:0] shaft_delta,
  input wire logic [15:0] turn_count,
  input wire logic [15:0] shaft_delta_snapshot,
  input wire logic        wdog_timeout_flag,
  input wire logic        compare_hit_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [16:0] idle_cnt;
  logic [31:0] prev_pos;
  // Idle cycles since position moved; parked at all ones after a flag clear
  always @(posedge clk) begin
    prev_pos <= position;
    if (rst || !wdog_en || position != prev_pos)
      idle_cnt <= 17'h00000;
    else if (wdog_flag_clear)
      idle_cnt <= 17'h1ffff;
    else if (idle_cnt != 17'h1ffff)
      idle_cnt <= idle_cnt + 17'h00001;
  end
  // Trigger clear request and its result
  sequence s_clear_req;
    trig_clear_en && $rose(trigger_in);
  endsequence
  sequence s_all_zero;
    position == 32'h0 && turn_count == 16'h0 && shaft_delta == 16'h0;
  endsequence
  property p_trig_clear;
    s_clear_req |-> ##[1:6] s_all_zero;
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger clear missed");
  property p_rst_vals;
    $fell(rst) |-> position == 32'h0 && turn_count == 16'h0 && !dma_req && !wdog_timeout_flag;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_sw_load;
    sw_load && !trig_clear_en |=> position == $past(sw_load_value);
  endproperty
  a_sw_load: assert property (p_sw_load) else $error("software load missed");
  property p_read_hit;
    hit_on_read && counters_read |=> compare_hit_pulse;
  endproperty
  a_read_hit: assert property (p_read_hit) else $error("no hit pulse on read");
  property p_wdog;
    wdog_en && idle_cnt == {1'b0, wdog_timeout} + 17'h00003 |-> wdog_timeout_flag;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog did not time out");
  property p_dma_ack;
    dma_req && dma_ack && !buf_write |=> !dma_req;
  endproperty
  a_dma_ack: assert property (p_dma_ack) else $error("dma request held after ack");
  property p_delta_read;
    delta_read |=> shaft_delta == 16'h0 || position != $past(position);
  endproperty
  a_delta_read: assert property (p_delta_read) else $error("delta not cleared by read");
  property p_snap_hold;
    period_meas_en && !delta_read && !trig_hold_en |=> $stable(shaft_delta_snapshot);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("delta snapshot moved");
endmodule
bind qdc_core qdc_core_sva qdc_core_sva_i (.*);
`default_nettype wire

// ---- qdc_sensor_model.sv ----
// Incremental sensor model: quadrature phases and index line
`timescale 1ns/100ps
`default_nettype none
module qdc_sensor_model (
  // Clock
  input wire logic  clk,
  // Requests from the bench
  input wire logic  step,
  input wire logic  step_up,
  input wire logic  index_req,
  // Sensor pins
  output wire logic quad_in_a,
  output wire logic quad_in_b,
  output wire logic index_in
);
  logic [1:0] phase = 2'h0;
  logic [1:0] next_phase = 2'h0;
  // Take the step request on the rising edge
  always @(posedge clk)
    if (step)
      next_phase <= step_up ? phase + 2'h1 : phase - 2'h1;
  // Pins move on the falling edge, away from the decoder's sampling
  always @(negedge clk)
    phase <= next_phase;
  // Gray-coded pair: phase a leads b when moving up
  assign quad_in_a = phase[0] ^ phase[1];
  assign quad_in_b = phase[1];
  assign index_in  = index_req;
endmodule
`default_nettype wire

// ---- quadrature_decoder_core_tb_top.sv ----
// Testbench for the quadrature decoder core
`timescale 1ns/100ps
`default_nettype none
`include "qdc_map.vh"
module quadrature_decoder_core_tb_top;
  logic        clk = 1'b0, rst = 1'b1, step = 1'b0, step_up = 1'b0, index_req = 1'b0, home_in = 1'b0;
  logic        trigger_in = 1'b0, reverse_en = 1'b0, one_shot = 1'b0, modulo_en = 1'b0, turn_on_roll = 1'b0;
  logic        hit_on_read = 1'b0, period_meas_en = 1'b0, trig_init_en = 1'b0, trig_clear_en = 1'b0;
  logic        trig_hold_en = 1'b0, wdog_en = 1'b0, wdog_flag_clear = 1'b0, buf_load_mode = 1'b0;
  logic        buf_write = 1'b0, dma_en = 1'b0, dma_ack = 1'b0, sw_load = 1'b0, delta_read = 1'b0;
  logic        counters_read = 1'b0;
  logic [1:0]  home_mode = `QDC_TM_OFF, index_mode = `QDC_TM_OFF;
  logic [3:0]  filt_bypass = 4'hf, prescale_sel = 4'h0;
  logic [7:0]  filt_period = 8'h02;
  logic [2:0]  filt_count = 3'h0, count_mode = `QDC_CM_X4;
  logic [15:0] wdog_timeout = 16'h0010;
  logic [31:0] buf_start_value = 32'h0, buf_wrap_value = 32'h0, buf_match_value0 = 32'h0, sw_load_value = 32'h0;
  wire         quad_in_a, quad_in_b, index_in, dma_req, last_dir_up, wdog_timeout_flag, compare_hit_pulse;
  wire  [31:0] position, position_snapshot;
  wire  [15:0] shaft_delta, turn_count, shaft_delta_snapshot, turn_snapshot;
  wire  [15:0] edge_age_timer, delta_period_timer, delta_period_snapshot;
  int          err_count = 0, comparisons = 0, hits = 0, i;
  // Free-running clock
  always #50 clk = ~clk;
  qdc_sensor_model qdc_sensor_model_i (.*);
  qdc_core qdc_core_i (.*, .buf_match_value1(32'hffff_fff0), .buf_match_value2(32'hffff_fff1),
    .buf_match_value3(32'hffff_fff2));
  // Wait falling edges, counting hit pulses seen
  task automatic cyc(input int n);
    repeat (n) begin
      @(negedge clk);
      if (compare_hit_pulse === 1'b1)
        hits++;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Move the sensor n counts
  task automatic move(input logic up, input int n);
    repeat (n) begin
      step_up = up;
      step = 1'b1;
      cyc(1);
      step = 1'b0;
      cyc(7);
    end
  endtask
  task automatic trig();
    trigger_in = 1'b1;
    cyc(8);
    trigger_in = 1'b0;
    cyc(8);
  endtask
  task automatic load(input logic [31:0] v);
    sw_load_value = v;
    sw_load = 1'b1;
    cyc(1);
    sw_load = 1'b0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence; returns early when a bounded wait runs out
  task automatic run();
    cyc(12);
    rst = 1'b0;
    move(1'b1, 3);
    chk(32'(last_dir_up), 32'h1, "dir up");
    move(1'b0, 1);
    chk(32'(last_dir_up), 32'h0, "dir down");
    reverse_en = 1'b1;
    move(1'b1, 2);
    chk(position, 32'h0, "reverse");
    chk(32'(shaft_delta), 32'h4, "delta");
    reverse_en = 1'b0;
    period_meas_en = 1'b1;
    delta_read = 1'b1;
    cyc(1);
    delta_read = 1'b0;
    move(1'b1, 1);
    chk(32'(shaft_delta_snapshot), 32'h4, "delta snap");
    hit_on_read = 1'b1;
    counters_read = 1'b1;
    cyc(1);
    counters_read = 1'b0;
    chk(32'(compare_hit_pulse), 32'h1, "read hit");
    chk(32'(shaft_delta_snapshot), 32'h4, "snap kept on read");
    period_meas_en = 1'b0;
    hit_on_read = 1'b0;
    $display("test count done");
    buf_start_value = 32'h10;
    buf_wrap_value = 32'h13;
    buf_match_value0 = 32'h12;
    buf_write = 1'b1;
    cyc(1);
    buf_write = 1'b0;
    modulo_en = 1'b1;
    turn_on_roll = 1'b1;
    load(32'h11);
    hits = 0;
    move(1'b1, 3);
    chk(position, 32'h10, "wrap");
    chk(32'(turn_count), 32'h1, "turn");
    chk(hits, 32'h1, "match");
    one_shot = 1'b1;
    load(32'h13);
    move(1'b1, 1);
    chk(position, 32'h13, "one shot");
    one_shot = 1'b0;
    modulo_en = 1'b0;
    turn_on_roll = 1'b0;
    $display("test modulo done");
    trig_init_en = 1'b1;
    trig();
    chk(position, 32'h10, "trig init");
    trig_init_en = 1'b0;
    move(1'b1, 1);
    trig_hold_en = 1'b1;
    trig();
    chk(position_snapshot, 32'h11, "hold pos");
    chk(32'(turn_snapshot), 32'h1, "hold turn");
    trig_hold_en = 1'b0;
    trig_clear_en = 1'b1;
    trig();
    chk(position, 32'h0, "clear pos");
    chk(32'(turn_count), 32'h0, "clear turn");
    chk(32'(shaft_delta), 32'h0, "clear delta");
    trig_clear_en = 1'b0;
    home_mode = `QDC_TM_RISE;
    home_in = 1'b1;
    cyc(8);
    chk(position, 32'h10, "home");
    home_mode = `QDC_TM_OFF;
    load(32'h0);
    index_mode = `QDC_TM_FALL;
    index_req = 1'b1;
    cyc(8);
    chk(position, 32'h0, "index rise");
    index_req = 1'b0;
    cyc(8);
    chk(position, 32'h10, "index fall");
    index_mode = `QDC_TM_OFF;
    $display("test trigger done");
    filt_bypass = 4'h3;
    move(1'b1, 1);
    chk(position, 32'h11, "bypass");
    chk(32'(edge_age_timer), 32'h3, "edge age");
    filt_bypass = 4'h0;
    cyc(40);
    step = 1'b1;
    cyc(1);
    step = 1'b0;
    cyc(5);
    chk(position, 32'h11, "filter early");
    cyc(30);
    chk(position, 32'h12, "filter late");
    filt_bypass = 4'hf;
    count_mode = `QDC_CM_X2;
    load(32'h0);
    move(1'b1, 4);
    chk(position, 32'h2, "x2 count");
    count_mode = `QDC_CM_X1;
    move(1'b1, 4);
    chk(position, 32'h3, "x1 count");
    count_mode = `QDC_CM_SGN1;
    move(1'b0, 4);
    chk(position, 32'h2, "signed count");
    count_mode = `QDC_CM_X4;
    $display("test filter done");
    wdog_en = 1'b1;
    cyc(10);
    chk(32'(wdog_timeout_flag), 32'h0, "wdog early");
    for (i = 0; i < 40 && wdog_timeout_flag !== 1'b1; i++)
      cyc(1);
    chk(32'(wdog_timeout_flag), 32'h1, "wdog");
    if (wdog_timeout_flag !== 1'b1)
      return;
    wdog_flag_clear = 1'b1;
    cyc(1);
    wdog_flag_clear = 1'b0;
    chk(32'(wdog_timeout_flag), 32'h0, "wdog clear");
    cyc(8);
    move(1'b1, 1);
    cyc(2);
    chk(32'(wdog_timeout_flag), 32'h0, "wdog restart");
    wdog_en = 1'b0;
    prescale_sel = 4'h2;
    delta_read = 1'b1;
    cyc(1);
    delta_read = 1'b0;
    cyc(40);
    chk(32'(delta_period_timer), 32'ha, "period timer");
    delta_read = 1'b1;
    cyc(1);
    delta_read = 1'b0;
    chk(32'(delta_period_snapshot), 32'ha, "period snap");
    prescale_sel = 4'h0;
    buf_load_mode = 1'b1;
    buf_start_value = 32'h20;
    buf_write = 1'b1;
    cyc(1);
    buf_write = 1'b0;
    trig_init_en = 1'b1;
    trig();
    chk(position, 32'h10, "held start");
    trig();
    chk(position, 32'h20, "moved start");
    trig_init_en = 1'b0;
    buf_load_mode = 1'b0;
    dma_en = 1'b1;
    buf_write = 1'b1;
    cyc(1);
    buf_write = 1'b0;
    for (i = 0; i < 20 && dma_req !== 1'b1; i++)
      cyc(1);
    chk(32'(dma_req), 32'h1, "dma req");
    if (dma_req !== 1'b1)
      return;
    dma_ack = 1'b1;
    cyc(1);
    dma_ack = 1'b0;
    chk(32'(dma_req), 32'h0, "dma ack");
    $display("test watchdog and dma done");
  endtask
  // Run the tests, then give the verdict
  initial begin
    run();
    end_sim();
  end
endmodule
`default_nettype wire
